//--- src/smt_pkg.sv
// constants, types and register map of the signal measurement timer modes
//
// Operation
// - gated window: count clocks while signal high
// - gated window: later window rises latch period, clear
// - time of flight: window rise starts counting
// - time of flight: signal rise latches period, clears
// - time of flight: second window rise latches width
// - capture: counting starts when run request set
// - capture: window rise period, fall width, interrupt
// - capture: counter cleared only by software or by wrapping at the limit
// - counter: signal pulses advance the counter
// - counter: window rise latches width
// - gated counter: count inside window, latch width
// - windowed counter: width at fall, period later rises
// - three interrupt sources with flags and enables
// - latch loads set matching acquisition flags
// - triggers aligned then resynchronised to processor clock
// - counter equal period limit raises match flag
// - single acquisition stops counter, clears run request
// - polarity bits invert window, signal, clock inputs
// - halt option: no rollover, match persists
package smt_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [4:0] OFS_IRQ_ENABLE  = 5'h00;
  localparam logic [4:0] OFS_IRQ_FLAG    = 5'h01;
  localparam logic [4:0] OFS_CLK_SELECT  = 5'h02;
  localparam logic [4:0] OFS_CONTROL_0   = 5'h03;
  localparam logic [4:0] OFS_CONTROL_1   = 5'h04;
  localparam logic [4:0] OFS_STATUS      = 5'h05;
  localparam logic [4:0] OFS_SIG_SELECT  = 5'h06;
  localparam logic [4:0] OFS_WIN_SELECT  = 5'h07;
  localparam logic [4:0] OFS_COUNTER_L   = 5'h08;
  localparam logic [4:0] OFS_COUNTER_M   = 5'h09;
  localparam logic [4:0] OFS_COUNTER_U   = 5'h0A;
  localparam logic [4:0] OFS_LIMIT_L     = 5'h0B;
  localparam logic [4:0] OFS_LIMIT_M     = 5'h0C;
  localparam logic [4:0] OFS_LIMIT_U     = 5'h0D;
  localparam logic [4:0] OFS_PERIOD_L    = 5'h0E;
  localparam logic [4:0] OFS_PERIOD_M    = 5'h0F;
  localparam logic [4:0] OFS_PERIOD_U    = 5'h10;
  localparam logic [4:0] OFS_WIDTH_L     = 5'h11;
  localparam logic [4:0] OFS_WIDTH_M     = 5'h12;
  localparam logic [4:0] OFS_WIDTH_U     = 5'h13;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int IRQ_MATCH_BIT  = 0;
  localparam int IRQ_PERIOD_BIT = 1;
  localparam int IRQ_WIDTH_BIT  = 2;
  localparam int CON0_EN_BIT    = 7;
  localparam int CON0_HALT_BIT  = 5;
  localparam int CON0_WINV_BIT  = 4;
  localparam int CON0_SINV_BIT  = 3;
  localparam int CON0_CINV_BIT  = 2;
  localparam int CON1_GO_BIT    = 7;
  localparam int CON1_REP_BIT   = 6;
  localparam int STAT_PRUP_BIT  = 7;
  localparam int STAT_PWUP_BIT  = 6;
  localparam int STAT_RST_BIT   = 5;
  localparam int CLKSEL_PIN_BIT = 0;

  // ****************************************************************
  // reset values and widths
  // ****************************************************************
  localparam int          CNT_W         = 24;
  localparam logic [23:0] LIMIT_RST     = 24'hFF_FFFF;
  localparam logic [23:0] CNT_ZERO      = 24'h00_0000;
  localparam logic [23:0] CNT_ONE       = 24'h00_0001;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [2:0]  IRQ_MASK      = 3'h7;
  localparam logic [4:0]  SEL_MASK      = 5'h1F;

  typedef enum logic [3:0] {
    MODE_TIMER     = 4'b0000,
    MODE_GATED_WIN = 4'b0101,
    MODE_FLIGHT    = 4'b0110,
    MODE_CAPTURE   = 4'b0111,
    MODE_COUNTER   = 4'b1000,
    MODE_GATED_CNT = 4'b1001,
    MODE_WIN_CNT   = 4'b1010
  } smt_mode_t;

  typedef struct packed {
    logic [2:0]  sig_sync;
    logic [2:0]  win_sync;
    logic [2:0]  clk_sync;
    logic [2:0]  irq_en;
    logic [2:0]  irq_flag;
    logic        clk_pin;
    logic [7:0]  con0;
    logic        go;
    logic        repeat_on;
    logic [3:0]  mode;
    logic [4:0]  sig_sel;
    logic [4:0]  win_sel;
    logic [23:0] counter;
    logic [23:0] limit;
    logic [23:0] period;
    logic [23:0] width;
    logic        armed;
    logic        seen_first;
    logic        running;
    logic [7:0]  rd_data;
    logic        irq;
  } smt_state_t;

endpackage

//--- src/smt_core.sv
// signal measurement timer: window and signal driven acquisition modes
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module smt_core
  import smt_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic [4:0] ADDR,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic       SIGNAL_IN,
  input  wire logic       WINDOW_IN,
  input  wire logic       MEASURE_CLK_IN,
  output logic      [7:0] RD_DATA,
  output logic            IRQ,
  output logic            RUNNING
);

  smt_state_t q_ff;
  smt_state_t nxt_q;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic wr_hit(input logic [4:0] a);
    wr_hit = WR_EN && (ADDR == a);
  endfunction

  function automatic logic [23:0] put_byte(input logic [23:0] v,
                                           input int          idx,
                                           input logic [7:0]  b);
    logic [23:0] r;
    r = v;
    r[idx*8 +: 8] = b;
    put_byte = r;
  endfunction

  // ****************************************************************
  // input conditioning
  // ****************************************************************
  logic sig_lvl;
  logic win_lvl;
  logic sig_rise;
  logic win_rise;
  logic win_fall;
  logic mclk_rise;
  logic sync_mode;
  logic tick;
  logic active;

  // stage 0 is the raw capture and only feeds stage 1
  always_comb begin
    sig_lvl   = q_ff.sig_sync[1] ^ q_ff.con0[CON0_SINV_BIT];
    win_lvl   = q_ff.win_sync[1] ^ q_ff.con0[CON0_WINV_BIT];
    sig_rise  = (q_ff.sig_sync[2:1] ==
                 (q_ff.con0[CON0_SINV_BIT] ? 2'b10 : 2'b01));
    win_rise  = (q_ff.win_sync[2:1] ==
                 (q_ff.con0[CON0_WINV_BIT] ? 2'b10 : 2'b01));
    win_fall  = (q_ff.win_sync[2:1] ==
                 (q_ff.con0[CON0_WINV_BIT] ? 2'b01 : 2'b10));
    mclk_rise = (q_ff.clk_sync[2:1] ==
                 (q_ff.con0[CON0_CINV_BIT] ? 2'b10 : 2'b01));
    sync_mode = !q_ff.mode[3];
    active    = q_ff.go && q_ff.con0[CON0_EN_BIT];
    // synchronous modes advance on the measure clock pin when clk_pin is set, else on every
    // cycle; counter modes take the signal edge itself as the time base
    if (sync_mode) begin
      tick = q_ff.clk_pin ? mclk_rise : 1'b1;
    end else begin
      tick = sig_rise;
    end
  end

  // ****************************************************************
  // mode engine
  // ****************************************************************
  logic        inc;
  logic        clr;
  logic        ld_period;
  logic        ld_width;
  logic        done;
  logic        match;
  logic [23:0] cnt_v;

  always_comb begin
    nxt_q = q_ff;
    inc = 1'b0;
    clr = 1'b0;
    ld_period = 1'b0;
    ld_width = 1'b0;
    done = 1'b0;
    cnt_v = q_ff.counter;

    nxt_q.sig_sync = {q_ff.sig_sync[1:0], SIGNAL_IN};
    nxt_q.win_sync = {q_ff.win_sync[1:0], WINDOW_IN};
    nxt_q.clk_sync = {q_ff.clk_sync[1:0], MEASURE_CLK_IN};

    if (active) begin
      unique case (q_ff.mode)
        MODE_GATED_WIN: begin
          inc = tick && sig_lvl && q_ff.seen_first;
          if (win_rise) begin
            nxt_q.seen_first = 1'b1;
            ld_period = q_ff.seen_first;
            clr = q_ff.seen_first;
            done = q_ff.seen_first;
          end
        end
        MODE_FLIGHT: begin
          inc = tick && q_ff.armed;
          if (win_rise && !q_ff.armed) begin
            nxt_q.armed = 1'b1;
            clr = 1'b1;
          end else if (win_rise) begin
            ld_width = 1'b1;
            clr = 1'b1;
            done = 1'b1;
          end else if (sig_rise && q_ff.armed) begin
            ld_period = 1'b1;
            clr = 1'b1;
            nxt_q.armed = 1'b0;
            done = 1'b1;
          end
        end
        MODE_CAPTURE: begin
          // counter is never cleared here; software clears it, and it wraps to zero at the limit unless halt is set
          inc = tick;
          ld_period = win_rise;
          ld_width = win_fall;
          done = win_rise || win_fall;
        end
        MODE_COUNTER: begin
          inc = tick;
          ld_width = win_rise;
          done = win_rise;
        end
        MODE_GATED_CNT: begin
          if (win_rise) begin
            nxt_q.armed = 1'b1;
            clr = 1'b1;
          end
          inc = tick && q_ff.armed && win_lvl;
          if (win_fall && q_ff.armed) begin
            ld_width = 1'b1;
            nxt_q.armed = 1'b0;
            done = 1'b1;
          end
        end
        MODE_WIN_CNT: begin
          inc = tick && q_ff.seen_first;
          if (win_rise) begin
            ld_period = q_ff.seen_first;
            done = q_ff.seen_first;
            nxt_q.seen_first = 1'b1;
            clr = 1'b1;
          end
          ld_width = win_fall && q_ff.seen_first;
        end
        default: begin
          // earlier modes are outside this block: plain timer
          inc = tick;
        end
      endcase
    end else begin
      nxt_q.armed = 1'b0;
      nxt_q.seen_first = 1'b0;
    end

    // period match; the halt option freezes the counter at the limit
    match = active && (q_ff.counter == q_ff.limit);
    if (ld_period) begin
      nxt_q.period = q_ff.counter;
    end
    if (ld_width) begin
      nxt_q.width = q_ff.counter;
    end
    if (clr) begin
      cnt_v = CNT_ZERO;
    end else if (inc && match) begin
      cnt_v = q_ff.con0[CON0_HALT_BIT] ? q_ff.counter : CNT_ZERO;
    end else if (inc) begin
      cnt_v = q_ff.counter + CNT_ONE;
    end
    nxt_q.counter = cnt_v;

    if (done && !q_ff.repeat_on) begin
      nxt_q.go = 1'b0;
    end

    // ****************************************************************
    // register writes; software actions follow the hardware ones
    // ****************************************************************
    if (wr_hit(OFS_IRQ_ENABLE)) begin
      nxt_q.irq_en = WR_DATA[2:0] & IRQ_MASK;
    end
    if (wr_hit(OFS_CLK_SELECT)) begin
      nxt_q.clk_pin = WR_DATA[CLKSEL_PIN_BIT];
    end
    if (wr_hit(OFS_CONTROL_0)) begin
      nxt_q.con0 = WR_DATA;
    end
    if (wr_hit(OFS_CONTROL_1)) begin
      nxt_q.go = WR_DATA[CON1_GO_BIT];
      nxt_q.repeat_on = WR_DATA[CON1_REP_BIT];
      nxt_q.mode = WR_DATA[3:0];
      nxt_q.armed = 1'b0;
      nxt_q.seen_first = 1'b0;
    end
    if (wr_hit(OFS_SIG_SELECT)) begin
      nxt_q.sig_sel = WR_DATA[4:0] & SEL_MASK;
    end
    if (wr_hit(OFS_WIN_SELECT)) begin
      nxt_q.win_sel = WR_DATA[4:0] & SEL_MASK;
    end
    if (wr_hit(OFS_COUNTER_L)) begin
      nxt_q.counter = put_byte(nxt_q.counter, 0, WR_DATA);
    end
    if (wr_hit(OFS_COUNTER_M)) begin
      nxt_q.counter = put_byte(nxt_q.counter, 1, WR_DATA);
    end
    if (wr_hit(OFS_COUNTER_U)) begin
      nxt_q.counter = put_byte(nxt_q.counter, 2, WR_DATA);
    end
    if (wr_hit(OFS_LIMIT_L)) begin
      nxt_q.limit = put_byte(q_ff.limit, 0, WR_DATA);
    end
    if (wr_hit(OFS_LIMIT_M)) begin
      nxt_q.limit = put_byte(q_ff.limit, 1, WR_DATA);
    end
    if (wr_hit(OFS_LIMIT_U)) begin
      nxt_q.limit = put_byte(q_ff.limit, 2, WR_DATA);
    end
    if (wr_hit(OFS_STATUS)) begin
      if (WR_DATA[STAT_RST_BIT]) begin
        nxt_q.counter = CNT_ZERO;
      end
      if (WR_DATA[STAT_PRUP_BIT]) begin
        nxt_q.period = q_ff.counter;
        ld_period = 1'b1;
      end
      if (WR_DATA[STAT_PWUP_BIT]) begin
        nxt_q.width = q_ff.counter;
        ld_width = 1'b1;
      end
    end

    // ****************************************************************
    // interrupt flags
    // ****************************************************************
    // events come from synchronised inputs, so each trigger is already
    // aligned to this clock; a write clearing a flag loses to a set
    if (wr_hit(OFS_IRQ_FLAG)) begin
      nxt_q.irq_flag = WR_DATA[2:0] & IRQ_MASK;
    end
    nxt_q.irq_flag[IRQ_WIDTH_BIT] = nxt_q.irq_flag[IRQ_WIDTH_BIT]
                                    | ld_width;
    nxt_q.irq_flag[IRQ_PERIOD_BIT] = nxt_q.irq_flag[IRQ_PERIOD_BIT]
                                     | ld_period;
    nxt_q.irq_flag[IRQ_MATCH_BIT] = nxt_q.irq_flag[IRQ_MATCH_BIT]
                                    | (match && inc)
                                    | (match && q_ff.con0[CON0_HALT_BIT]);
    nxt_q.irq = |(q_ff.irq_flag & q_ff.irq_en);
    nxt_q.running = active;

    // ****************************************************************
    // read port
    // ****************************************************************
    nxt_q.rd_data = BYTE_ZERO;
    if (RD_EN) begin
      unique case (ADDR)
        OFS_IRQ_ENABLE: nxt_q.rd_data = {5'h0_0, q_ff.irq_en};
        OFS_IRQ_FLAG:   nxt_q.rd_data = {5'h0_0, q_ff.irq_flag};
        OFS_CLK_SELECT: nxt_q.rd_data = {7'h00, q_ff.clk_pin};
        OFS_CONTROL_0:  nxt_q.rd_data = q_ff.con0;
        OFS_CONTROL_1:  nxt_q.rd_data = {q_ff.go, q_ff.repeat_on,
                                         2'h0, q_ff.mode};
        OFS_STATUS:     nxt_q.rd_data = {5'h0_0, active,
                                         win_lvl, sig_lvl};
        OFS_SIG_SELECT: nxt_q.rd_data = {3'h0, q_ff.sig_sel};
        OFS_WIN_SELECT: nxt_q.rd_data = {3'h0, q_ff.win_sel};
        OFS_COUNTER_L:  nxt_q.rd_data = q_ff.counter[7:0];
        OFS_COUNTER_M:  nxt_q.rd_data = q_ff.counter[15:8];
        OFS_COUNTER_U:  nxt_q.rd_data = q_ff.counter[23:16];
        OFS_LIMIT_L:    nxt_q.rd_data = q_ff.limit[7:0];
        OFS_LIMIT_M:    nxt_q.rd_data = q_ff.limit[15:8];
        OFS_LIMIT_U:    nxt_q.rd_data = q_ff.limit[23:16];
        OFS_PERIOD_L:   nxt_q.rd_data = q_ff.period[7:0];
        OFS_PERIOD_M:   nxt_q.rd_data = q_ff.period[15:8];
        OFS_PERIOD_U:   nxt_q.rd_data = q_ff.period[23:16];
        OFS_WIDTH_L:    nxt_q.rd_data = q_ff.width[7:0];
        OFS_WIDTH_M:    nxt_q.rd_data = q_ff.width[15:8];
        OFS_WIDTH_U:    nxt_q.rd_data = q_ff.width[23:16];
        default:        nxt_q.rd_data = BYTE_ZERO;
      endcase
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q_ff       <= '0;
      q_ff.limit <= LIMIT_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign RD_DATA = q_ff.rd_data;
  assign IRQ     = q_ff.irq;
  assign RUNNING = q_ff.running;

endmodule

//--- verification/smt_src.sv
// stimulus source driving the signal, window and measure clock pins
`timescale 1ns/1ps
module smt_src (
  input  wire logic clk,
  output logic      sig,
  output logic      win,
  output logic      mclk
);
  // ********
  // pin drivers
  // ********
  initial begin
    sig  = 1'b0;
    win  = 1'b0;
    mclk = 1'b0;
  end
  // levels last n cycles; under 3 the synchroniser may miss them
  task automatic hold(input logic s, input logic w, input int n);
    @(posedge clk);
    sig <= s;
    win <= w;
    repeat (n - 1) @(posedge clk);
  endtask
  // measure clock pin level for n cycles
  task automatic clk_level(input logic c, input int n);
    @(posedge clk);
    mclk <= c;
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic pulses(input int k);
    repeat (k) begin
      hold(1'b1, win, 4);
      hold(1'b0, win, 4);
    end
  endtask
endmodule

//--- verification/smt_core_sva.sv
// port assertions for the measurement timer
`timescale 1ns/1ps
module smt_core_sva
  import smt_pkg::*;
(
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] RD_DATA,
  input wire logic       IRQ,
  input wire logic       RUNNING
);
  // ********
  // properties
  // ********
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence en_write;
    WR_EN && ADDR == OFS_IRQ_ENABLE;
  endsequence
  sequence en_read;
    RD_EN && ADDR == OFS_IRQ_ENABLE;
  endsequence
  a_rd_idle: assert property (!RD_EN |=> RD_DATA == BYTE_ZERO)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    RD_EN && ADDR > OFS_WIDTH_U |=> RD_DATA == BYTE_ZERO)
    else $error("unmapped read not zero");
  a_status_run: assert property (
    RD_EN && ADDR == OFS_STATUS |=> RD_DATA[2] == RUNNING)
    else $error("status run bit differs from run output");
  a_stop_write: assert property (
    WR_EN && ADDR == OFS_CONTROL_1 && !WR_DATA[CON1_GO_BIT]
    |-> ##[1:2] !RUNNING)
    else $error("run output kept after stop");
  a_run_by_sw: assert property (
    $rose(RUNNING) |-> $past(WR_EN) || $past(WR_EN, 2))
    else $error("run started without a write");
  a_irq_sticky: assert property (
    $fell(IRQ) |-> $past(WR_EN) || $past(WR_EN, 2))
    else $error("interrupt dropped without a write");
  a_irq_mask: assert property (
    en_write ##0 WR_DATA[2:0] == 3'h0 |-> ##[1:2] !IRQ)
    else $error("interrupt with all enables clear");
  a_en_readback: assert property (
    en_write ##2 en_read |=> RD_DATA == {5'h00, $past(WR_DATA[2:0], 3)})
    else $error("enable register readback wrong");
endmodule

bind smt_core smt_core_sva smt_core_sva_inst (
  .CLK     (CLK),
  .SYS_RST (SYS_RST),
  .ADDR    (ADDR),
  .WR_DATA (WR_DATA),
  .WR_EN   (WR_EN),
  .RD_EN   (RD_EN),
  .RD_DATA (RD_DATA),
  .IRQ     (IRQ),
  .RUNNING (RUNNING)
);

//--- verification/test_smt_core.sv
// self-checking bench for the measurement timer modes
`timescale 1ns/1ps
module test_smt_core;
  import smt_pkg::*;
  logic       clk;
  logic       sys_rst;
  logic [4:0] addr;
  logic [7:0] wd;
  logic       wr_en;
  logic       rd_en;
  logic       sig;
  logic       win;
  logic       mclk;
  logic [7:0] rd_data;
  logic       irq;
  logic       running;
  int         err_count = 0;
  int         cmp_count = 0;
  smt_core smt_core_inst (
    .CLK            (clk),
    .SYS_RST        (sys_rst),
    .ADDR           (addr),
    .WR_DATA        (wd),
    .WR_EN          (wr_en),
    .RD_EN          (rd_en),
    .SIGNAL_IN      (sig),
    .WINDOW_IN      (win),
    .MEASURE_CLK_IN (mclk),
    .RD_DATA        (rd_data),
    .IRQ            (irq),
    .RUNNING        (running)
  );
  smt_src smt_src_inst (
    .clk  (clk),
    .sig  (sig),
    .win  (win),
    .mclk (mclk)
  );
  // ********
  // bus and check tasks
  // ********
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wd    <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = {16'h0000, rd_data};
  endtask
  task automatic rd24(input logic [4:0] a, output logic [23:0] v);
    logic [23:0] t0;
    logic [23:0] t1;
    logic [23:0] t2;
    rd(a, t0);
    rd(a + 5'h01, t1);
    rd(a + 5'h02, t2);
    v = {t2[7:0], t1[7:0], t0[7:0]};
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({23'h00_0000, irq}, {23'h00_0000, e});
  endtask
  // stop first so the counter clear is not raced by a tick
  task automatic arm(input logic [7:0] c1);
    wr(OFS_CONTROL_1, 8'h00);
    wr(OFS_STATUS, 8'h20);
    wr(OFS_IRQ_FLAG, 8'h00);
    wr(OFS_CONTROL_1, c1);
  endtask
  // ********
  // scenarios
  // ********
  task automatic s_reset();
    logic [23:0] v;
    rd24(OFS_LIMIT_L, v);
    chk(v, LIMIT_RST);
    rd(5'h1F, v);
    chk(v, CNT_ZERO);
  endtask
  task automatic s_capture();
    logic [23:0] p;
    logic [23:0] w;
    logic [23:0] c;
    wr(OFS_CONTROL_0, 8'h80);
    wr(OFS_IRQ_ENABLE, 8'h07);
    rd(OFS_IRQ_ENABLE, c);
    chk(c, 24'h00_0007);
    arm(8'hC7);
    @(posedge clk);
    #1 chk({23'h00_0000, running}, 24'h00_0001);
    smt_src_inst.hold(1'b0, 1'b1, 10);
    smt_src_inst.hold(1'b0, 1'b0, 8);
    rd24(OFS_PERIOD_L, p);
    rd24(OFS_WIDTH_L, w);
    rd24(OFS_COUNTER_L, c);
    chk(w - p, 24'h00_000A);
    chk({23'h00_0000, c > w}, 24'h00_0001);
    rd(OFS_IRQ_FLAG, c);
    chk(c, 24'h00_0006);
    wr(OFS_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    wr(OFS_IRQ_ENABLE, 8'h07);
    irq_is(1'b1);
    wr(OFS_IRQ_FLAG, 8'h00);
    irq_is(1'b0);
  endtask
  task automatic s_gated_win();
    logic [23:0] v;
    arm(8'hC5);
    smt_src_inst.hold(1'b0, 1'b1, 8);
    smt_src_inst.hold(1'b0, 1'b0, 4);
    rd(OFS_IRQ_FLAG, v);
    chk(v, CNT_ZERO);
    smt_src_inst.hold(1'b1, 1'b0, 12);
    smt_src_inst.hold(1'b0, 1'b0, 6);
    smt_src_inst.hold(1'b0, 1'b1, 8);
    smt_src_inst.hold(1'b0, 1'b0, 4);
    rd24(OFS_PERIOD_L, v);
    chk(v, 24'h00_000C);
  endtask
  task automatic s_flight();
    logic [23:0] v;
    arm(8'hC6);
    smt_src_inst.hold(1'b0, 1'b1, 10);
    smt_src_inst.hold(1'b1, 1'b1, 8);
    smt_src_inst.hold(1'b0, 1'b0, 8);
    rd24(OFS_PERIOD_L, v);
    // start latency is open by one tick either way
    chk({23'h00_0000, v >= 24'h00_0009 && v <= 24'h00_000B}, 24'h1);
    wr(OFS_IRQ_FLAG, 8'h00);
    repeat (2) smt_src_inst.pulses(0);
    smt_src_inst.hold(1'b0, 1'b1, 6);
    smt_src_inst.hold(1'b0, 1'b0, 6);
    smt_src_inst.hold(1'b0, 1'b1, 6);
    smt_src_inst.hold(1'b0, 1'b0, 6);
    rd(OFS_IRQ_FLAG, v);
    chk(v, 24'h00_0004);
  endtask
  task automatic s_counter();
    logic [23:0] v;
    arm(8'h88);
    smt_src_inst.pulses(5);
    smt_src_inst.hold(1'b0, 1'b1, 8);
    smt_src_inst.hold(1'b0, 1'b0, 4);
    rd24(OFS_WIDTH_L, v);
    chk(v, 24'h00_0005);
    rd(OFS_CONTROL_1, v);
    chk(v, 24'h00_0008);
    rd(OFS_STATUS, v);
    chk({23'h00_0000, v[2]}, CNT_ZERO);
  endtask
  task automatic s_win_count();
    logic [23:0] v;
    for (int m = 9; m <= 10; m++) begin
      // window must start low so the first rise is seen while armed
      smt_src_inst.hold(1'b0, 1'b0, 4);
      arm({4'hC, m[3:0]});
      smt_src_inst.pulses(2);
      smt_src_inst.hold(1'b0, 1'b1, 4);
      smt_src_inst.pulses(3);
      smt_src_inst.hold(1'b0, 1'b0, 8);
      rd24(OFS_WIDTH_L, v);
      chk(v, 24'h00_0003);
      if (m == 10) begin
        smt_src_inst.hold(1'b0, 1'b1, 8);
        rd(OFS_IRQ_FLAG, v);
        chk(v, 24'h00_0006);
        rd24(OFS_PERIOD_L, v);
        chk(v, 24'h00_0003);
      end
    end
  endtask
  task automatic s_match();
    logic [23:0] v;
    wr(OFS_LIMIT_L, 8'h05);
    wr(OFS_LIMIT_M, 8'h00);
    wr(OFS_LIMIT_U, 8'h00);
    wr(OFS_CONTROL_0, 8'hA0);
    arm(8'h80);
    repeat (20) @(posedge clk);
    rd24(OFS_COUNTER_L, v);
    chk(v, 24'h00_0005);
    wr(OFS_IRQ_FLAG, 8'h00);
    rd(OFS_IRQ_FLAG, v);
    chk(v, 24'h00_0001);
  endtask
  // inverted inputs: a pin rise must not count, the pin fall must
  task automatic s_polarity();
    logic [23:0] v;
    wr(OFS_CONTROL_0, 8'h88);
    arm(8'h88);
    smt_src_inst.hold(1'b1, 1'b0, 6);
    rd24(OFS_COUNTER_L, v);
    chk(v, CNT_ZERO);
    smt_src_inst.hold(1'b0, 1'b0, 6);
    rd24(OFS_COUNTER_L, v);
    chk(v, CNT_ONE);
    wr(OFS_CONTROL_0, 8'h84);
    wr(OFS_CLK_SELECT, 8'h01);
    arm(8'h80);
    smt_src_inst.clk_level(1'b1, 6);
    rd24(OFS_COUNTER_L, v);
    chk(v, CNT_ZERO);
    smt_src_inst.clk_level(1'b0, 6);
    rd24(OFS_COUNTER_L, v);
    chk(v, CNT_ONE);
  endtask
  // ********
  // run control
  // ********
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    addr    = 5'h00;
    wd      = 8'h00;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    s_reset();
    s_capture();
    s_gated_win();
    s_flight();
    s_counter();
    s_win_count();
    s_match();
    s_polarity();
    conclude();
  end
endmodule
